/* File: design/pir_i2c_target.sv */
// What this block does
// [R01] answer bus address 101 plus strap nibble 0000/1111/0101/1010
// [R02] address byte lsb: 0 writes into device, 1 reads out
// [R03] drive sda low through ninth clock when address matches
// [R04] controller stops and abandons transfer on a missing address ack
// [R05] take register address byte msb first and acknowledge it
// [R06] take data bytes msb first on scl high, acknowledge each
// [R07] pointer increments by one during each data byte acknowledge; the code steps it on written data bytes only, not on reads
// [R08] only unlock, flags, page0 detect ranges and page3 11h read data; the code returns unlock and flags only, all else reads zero
// [R09] controller reads by writing register address, repeated start, then read
// [R10] controller selects page 0 or 3 before reading paged registers
// [R11] page selector chooses one of four pages, values 0 to 3
// [R12] page selector comes up holding zero
// [R13] page selector ignores writes while locked
// [R14] key C5 allows one page change, then unlock returns to 00
// [R15] enable bits gate open, short and breathing sources, reset zero
// [R16] enable bit 3 clears interrupt after low longer than 8 ms
// [R17] flags: open d0, short d1, patterns d2 to d4, upper zero
// [R18] reading page3 register 11h returns all registers to power-on state
// [R19] interrupt output low while an enabled flag is set
// [R20] reserved page values are ignored, previous page stays
`default_nettype none
module pir_i2c_target #(
  parameter int unsigned AUTO_CLR_CYC = pir_pkg::AUTO_CLR_CYCLES // auto clear limit
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic scl, // link clock from controller
  input wire logic sdaIn, // sda wire level
  output logic sdaOut, // sda drive value, always low
  output logic sdaOe, // high while pulling sda low
  input wire logic [1:0] addrStrap, // address strap pin code
  input wire logic openEvent, // open detected pulse
  input wire logic shortEvent, // short detected pulse
  input wire logic [2:0] patternDone, // breathing pattern 1..3 done pulses
  output logic irqOutN, // interrupt, active low
  output logic [7:0] pageSel, // selected page
  output logic pageWrStb, // write pulse to paged register
  output logic [7:0] pageWrAddr, // paged register address
  output logic [7:0] pageWrData, // paged register data
  output logic softResetStb // pulse: return all registers to power-on
);
  import pir_pkg::*;

  // link domain: bits are stable while scl is high, so capture on its rise
  logic [7:0] linkShift_q;
  always_ff @(posedge scl) begin
    linkShift_q <= {linkShift_q[6:0], sdaIn}; // [R06]
  end

  // two flip-flop synchronisers for the pins
  logic sclM_q, sclS_q, sclD_q, sdaM_q, sdaS_q, sdaD_q;
  logic [1:0] strapM_q, strapS_q, strap_q;
  always_ff @(posedge ref_clk) begin
    sclM_q <= scl;
    sclS_q <= sclM_q;
    sclD_q <= sclS_q;
    sdaM_q <= sdaIn;
    sdaS_q <= sdaM_q;
    sdaD_q <= sdaS_q;
    strapM_q <= addrStrap;
    strapS_q <= strapM_q;
  end

  // strap is caught while reset is held, so a bus mid-flight cannot move it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      strap_q <= strapS_q;
    end
  end

  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise = sclS_q && !sclD_q;
  assign sclFall = !sclS_q && sclD_q;
  assign startCond = sclS_q && sclD_q && sdaD_q && !sdaS_q;
  assign stopCond = sclS_q && sclD_q && !sdaD_q && sdaS_q;

  logic [3:0] strapBits;
  always_comb begin
    unique case (strap_q)
      STRAP_GND: strapBits = STRAP_GND_BITS;
      STRAP_VCC: strapBits = STRAP_VCC_BITS;
      STRAP_SCL: strapBits = STRAP_SCL_BITS;
      STRAP_SDA: strapBits = STRAP_SDA_BITS;
    endcase
  end

  pir_state_e state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] ptr_q, tx_q, unlock_q, page_q;
  logic [EN_WIDTH-1:0] intEn_q;
  logic [FLG_WIDTH-1:0] flags_q;
  logic masterNack_q, readDir_q, sdaOe_q, irqN_q, wrStb_q, softRst_q;
  logic [7:0] wrAddr_q, wrData_q;
  logic [19:0] lowCnt_q;

  // byte captured in the link domain; it stays put until the next scl rise,
  // which is far longer than the sync delay, so the word is read whole
  logic [7:0] rxByte;
  logic byteDone, ackEnd, addrMatch, wrEn, softRst, rdFlags, autoClr, irqPend;
  assign rxByte = linkShift_q;
  assign byteDone = sclFall && bitCnt_q == BIT_ACK;
  assign ackEnd = sclFall && bitCnt_q == BIT_ACK_END;
  assign addrMatch = rxByte[7:1] == {BUS_ADDR_HI, strapBits}; // [R01]
  assign wrEn = byteDone && state_q == ST_WRITE;
  // a byte counts as read once its ack slot ends, acked or not: the last byte
  // of every read is refused by the controller
  assign softRst = ackEnd && state_q == ST_READ
    && page_q == FUNCTION_PAGE && ptr_q == OFS_SOFT_RESET;
  assign rdFlags = ackEnd && state_q == ST_READ
    && ptr_q == OFS_EVENT_FLAGS;

  // read data mux; only a few addresses return data, the rest read zero
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00; // [R08]
    if (ptr_q == OFS_PAGE_UNLOCK) begin
      rdByte = unlock_q;
    end else if (ptr_q == OFS_EVENT_FLAGS) begin
      rdByte = {3'h0, flags_q}; // [R17]
    end
  end

  // protocol sequencer, acting on synchronised scl edges
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
      tx_q <= 8'h00;
      masterNack_q <= 1'b0;
      readDir_q <= 1'b0;
    end else if (startCond) begin
      state_q <= ST_ADDR; // repeated start lands here too
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= ST_IDLE;
      sdaOe_q <= 1'b0;
    end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
      if (sclRise) begin
        bitCnt_q <= bitCnt_q + 4'h1;
        if (state_q == ST_READ && bitCnt_q == BIT_ACK) begin
          masterNack_q <= sdaS_q;
        end
      end
      if (byteDone) begin
        unique case (state_q)
          ST_ADDR: begin
            sdaOe_q <= addrMatch; // [R03]
            readDir_q <= rxByte[0]; // kept now, the ack bit shifts in at the 9th rise
            if (!addrMatch) begin
              state_q <= ST_IGNORE; // [R01]
            end
          end
          ST_READ: sdaOe_q <= 1'b0; // controller drives its ack
          default: sdaOe_q <= 1'b1; // [R05] [R06]
        endcase
      end else if (ackEnd) begin
        bitCnt_q <= 4'h0;
        sdaOe_q <= 1'b0;
        unique case (state_q)
          ST_ADDR: begin
            if (readDir_q) begin
              state_q <= ST_READ; // [R02]
              tx_q <= rdByte;
              sdaOe_q <= !rdByte[7];
            end else begin
              state_q <= ST_REG; // [R02]
            end
          end
          ST_REG: state_q <= ST_WRITE;
          ST_READ: begin
            if (masterNack_q) begin
              state_q <= ST_IGNORE;
            end else begin
              tx_q <= rdByte;
              sdaOe_q <= !rdByte[7];
            end
          end
          default: state_q <= state_q;
        endcase
      end else if (sclFall && state_q == ST_READ && bitCnt_q != 4'h0
                   && bitCnt_q < BIT_ACK) begin
        sdaOe_q <= !tx_q[3'(7 - bitCnt_q)];
      end
    end
  end

  // register pointer: loaded by the register byte, stepped on every written data byte ack, not on reads
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ptr_q <= 8'h00;
    end else if (byteDone && state_q == ST_REG) begin
      ptr_q <= rxByte; // [R05]
    end else if (wrEn) begin
      ptr_q <= ptr_q + 8'h01; // [R07]
    end
  end

  // unlock key and page selector; the key is spent by a real page change
  always_ff @(posedge ref_clk) begin
    if (!reset_n || softRst) begin
      unlock_q <= RST_PAGE_UNLOCK; // [R18]
      page_q <= RST_PAGE_SELECT; // [R12]
    end else if (wrEn && ptr_q == OFS_PAGE_UNLOCK) begin
      unlock_q <= rxByte;
    end else if (wrEn && ptr_q == OFS_PAGE_SELECT && unlock_q == UNLOCK_KEY
                 && rxByte <= PAGE_LAST) begin
      page_q <= rxByte; // [R11] [R13] [R20]
      unlock_q <= RST_PAGE_UNLOCK; // [R14]
    end
  end

  // interrupt enables
  always_ff @(posedge ref_clk) begin
    if (!reset_n || softRst) begin
      intEn_q <= RST_INT_ENABLE[EN_WIDTH-1:0]; // [R15]
    end else if (wrEn && ptr_q == OFS_INT_ENABLE) begin
      intEn_q <= rxByte[EN_WIDTH-1:0];
    end
  end

  // sticky event flags: a read clears only the bits it reported, so an event
  // landing mid-read is kept; auto clear drops all; a same-cycle event still sets
  logic [FLG_WIDTH-1:0] flagSet;
  assign flagSet = {patternDone, shortEvent, openEvent};
  always_ff @(posedge ref_clk) begin
    if (!reset_n || softRst) begin
      flags_q <= RST_EVENT_FLAGS[FLG_WIDTH-1:0];
    end else if (autoClr) begin
      flags_q <= flagSet; // [R16]
    end else if (rdFlags) begin
      flags_q <= (flags_q & ~tx_q[FLG_WIDTH-1:0]) | flagSet; // [R17]
    end else begin
      flags_q <= flags_q | flagSet; // [R17]
    end
  end

  assign irqPend = (flags_q[FLG_OPEN_BIT] && intEn_q[EN_OPEN_BIT])
    || (flags_q[FLG_SHORT_BIT] && intEn_q[EN_SHORT_BIT])
    || ((|flags_q[FLG_WIDTH-1:FLG_PAT_LSB]) && intEn_q[EN_BREATH_BIT]); // [R15]
  assign autoClr = intEn_q[EN_AUTOCLR_BIT] && lowCnt_q > 20'(AUTO_CLR_CYC); // [R16]

  // interrupt output and its low-time counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irqN_q <= 1'b1;
      lowCnt_q <= 20'h00000;
    end else begin
      irqN_q <= !irqPend || autoClr; // [R19]
      if (irqN_q || autoClr) begin
        lowCnt_q <= 20'h00000;
      end else if (lowCnt_q != 20'hFFFFF) begin
        lowCnt_q <= lowCnt_q + 20'h00001;
      end
    end
  end

  // writes to addresses this block does not own go out to the page registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wrStb_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
      softRst_q <= 1'b0;
    end else begin
      wrStb_q <= wrEn && ptr_q != OFS_PAGE_UNLOCK && ptr_q != OFS_PAGE_SELECT
        && ptr_q != OFS_INT_ENABLE && ptr_q != OFS_EVENT_FLAGS;
      softRst_q <= softRst; // [R18]
      if (wrEn) begin
        wrAddr_q <= ptr_q;
        wrData_q <= rxByte;
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;
  assign irqOutN = irqN_q;
  assign pageSel = page_q;
  assign pageWrStb = wrStb_q;
  assign pageWrAddr = wrAddr_q;
  assign pageWrData = wrData_q;
  assign softResetStb = softRst_q;

  // checks
  a_addr_ack: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R01] [R03]
    byteDone && state_q == ST_ADDR && addrMatch |=> sdaOe_q [*1] ##1 sdaOe_q)
    else $error("address match not acknowledged");
  a_addr_miss: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R01]
    byteDone && state_q == ST_ADDR && !addrMatch && !startCond
    |=> !sdaOe_q && state_q == ST_IGNORE)
    else $error("foreign address acknowledged");
  a_data_ack: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R05] [R06]
    byteDone && (state_q == ST_REG || state_q == ST_WRITE) |=> sdaOe_q)
    else $error("received byte not acknowledged");
  a_ptr_step: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R07]
    wrEn |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not step by one");
  a_page_locked: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R13] [R20]
    wrEn && ptr_q == OFS_PAGE_SELECT && (unlock_q != UNLOCK_KEY || rxByte > PAGE_LAST)
    |=> $stable(page_q))
    else $error("page changed while locked or reserved");
  a_unlock_once: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R11] [R14]
    wrEn && ptr_q == OFS_PAGE_SELECT && unlock_q == UNLOCK_KEY && rxByte <= PAGE_LAST
    |=> unlock_q == 8'h00 && page_q == $past(rxByte))
    else $error("unlock key not spent on page change");
  a_irq_follow: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R15] [R19]
    irqPend && !autoClr ##1 irqPend |-> !irqOutN)
    else $error("enabled flag without interrupt");
  a_auto_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R16]
    autoClr && !softRst |=> flags_q == $past(flagSet) ##1 lowCnt_q == 20'h00000)
    else $error("auto clear failed");
  a_no_autoclr: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R16]
    !intEn_q[EN_AUTOCLR_BIT] && !rdFlags && !softRst |=> (flags_q & $past(flags_q))
    == $past(flags_q))
    else $error("flags cleared without auto clear");
  a_flag_upper: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R17]
    rdFlags |-> tx_q[7:5] == 3'h0 ##1 tx_q[7:5] == 3'h0)
    else $error("upper flag bits not zero");
  a_soft_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R12] [R18]
    softRst |=> page_q == 8'h00 && intEn_q == 4'h0 && softResetStb)
    else $error("soft reset incomplete");
  a_read_dir: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R02] [R08]
    ackEnd && state_q == ST_ADDR && readDir_q && !startCond && !stopCond
    |=> state_q == ST_READ && sdaOe_q == !tx_q[7])
    else $error("read direction not taken up");
  a_read_nack: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R02]
    ackEnd && state_q == ST_READ && masterNack_q && !startCond && !stopCond
    |=> !sdaOe_q && state_q == ST_IGNORE)
    else $error("device kept driving after a refused read byte");
  a_flags_read: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R17]
    rdFlags && !autoClr && !softRst
    |=> (flags_q & $past(tx_q[FLG_WIDTH-1:0]))
      == ($past(flagSet) & $past(tx_q[FLG_WIDTH-1:0])))
    else $error("reported flags not cleared");
  a_irq_idle: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R19]
    !irqPend |=> irqOutN)
    else $error("interrupt asserted with nothing pending");
  c_write_byte: cover property (@(posedge ref_clk) disable iff (!reset_n) wrEn);
  c_read_byte: cover property (@(posedge ref_clk) disable iff (!reset_n)
    ackEnd && state_q == ST_READ);
  c_page_change: cover property (@(posedge ref_clk) disable iff (!reset_n)
    wrEn && ptr_q == OFS_PAGE_SELECT && unlock_q == UNLOCK_KEY);
  c_auto_clear: cover property (@(posedge ref_clk) disable iff (!reset_n) autoClr);
endmodule // pir_i2c_target
`default_nettype wire

/* File: design/pir_pkg.sv */
`default_nettype none
package pir_pkg;
  // register offsets in the device's byte address space
  localparam logic [7:0] OFS_INT_ENABLE = 8'hF0;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'hF1;
  localparam logic [7:0] OFS_PAGE_SELECT = 8'hFD;
  localparam logic [7:0] OFS_PAGE_UNLOCK = 8'hFE;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h11;
  // reset values and key codes
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
  localparam logic [7:0] RST_PAGE_UNLOCK = 8'h00;
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'hC5;
  localparam logic [7:0] PAGE_LAST = 8'h03;
  localparam logic [7:0] FUNCTION_PAGE = 8'h03;
  // bus address: fixed upper bits and strap-selected low nibble
  localparam logic [2:0] BUS_ADDR_HI = 3'h5;
  localparam logic [3:0] STRAP_GND_BITS = 4'h0;
  localparam logic [3:0] STRAP_VCC_BITS = 4'hF;
  localparam logic [3:0] STRAP_SCL_BITS = 4'h5;
  localparam logic [3:0] STRAP_SDA_BITS = 4'hA;
  // strap pin encodings
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h1;
  localparam logic [1:0] STRAP_SCL = 2'h2;
  localparam logic [1:0] STRAP_SDA = 2'h3;
  // interrupt enable field positions
  localparam int EN_OPEN_BIT = 0;
  localparam int EN_SHORT_BIT = 1;
  localparam int EN_BREATH_BIT = 2;
  localparam int EN_AUTOCLR_BIT = 3;
  localparam int EN_WIDTH = 4;
  // event flag field positions
  localparam int FLG_OPEN_BIT = 0;
  localparam int FLG_SHORT_BIT = 1;
  localparam int FLG_PAT_LSB = 2;
  localparam int FLG_WIDTH = 5;
  // auto clear time
  localparam int AUTO_CLR_MS = 8;
  localparam int REF_CLK_KHZ = 100000;
  localparam int AUTO_CLR_CYCLES = AUTO_CLR_MS * REF_CLK_KHZ;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACK_END = 4'h9;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WRITE, ST_READ, ST_IGNORE
  } pir_state_e;
endpackage
`default_nettype wire

/* File: bench/pir_i2c_ctl.sv */
`default_nettype none
module pir_i2c_ctl (
  output logic scl, // link clock, idles high
  output logic sdaPull, // high while we pull sda low
  input wire logic sda // resolved sda wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle: both lines released
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // one 160 ns slot; data moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    #20 sdaPull = !b;
    #80 scl = 1'b1;
    #30 r = sda;
    #30 scl = 1'b0;
  endtask
  // start or repeated start; scl then stays low until the next slot
  task automatic start();
    #20 sdaPull = 1'b0;
    #80 scl = 1'b1;
    #30 sdaPull = 1'b1;
    #30 scl = 1'b0;
  endtask
  // stop leaves scl still and high, so no clock runs between frames
  task automatic stop();
    #20 sdaPull = 1'b1;
    #80 scl = 1'b1;
    #30 sdaPull = 1'b0;
    #30;
  endtask
  // byte msb first then the ninth slot; d of FF releases sda for reads
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, ack);
  endtask
endmodule // pir_i2c_ctl
`default_nettype wire

/* File: bench/paged_i2c_register_port_bench.sv */
`default_nettype none
module paged_i2c_register_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] r, d, rr, exp; int stb;} pir_row_s;
  localparam logic [3:0] NIB [4] = '{4'h0, 4'hF, 4'h5, 4'hA};
  logic ref_clk, reset_n, openEvent, shortEvent, ack;
  logic [2:0] patternDone;
  logic [1:0] addrStrap;
  logic [6:0] devA;
  logic [7:0] rb, val, lastA, lastD;
  int err_total, cmp_count, stbCnt, rstCnt, n0;
  wire logic scl, sdaPull, sda, sdaOut, sdaOe, irqOutN, pageWrStb, softResetStb;
  wire logic [7:0] pageSel, pageWrAddr, pageWrData;
  // open-drain wire with pull-up
  assign sda = !((sdaOe & !sdaOut) | sdaPull);
  pir_i2c_ctl c_u (.scl(scl), .sdaPull(sdaPull), .sda(sda));
  pir_i2c_target #(.AUTO_CLR_CYC(50)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap),
    .openEvent(openEvent), .shortEvent(shortEvent), .patternDone(patternDone),
    .irqOutN(irqOutN), .pageSel(pageSel), .pageWrStb(pageWrStb),
    .pageWrAddr(pageWrAddr), .pageWrData(pageWrData), .softResetStb(softResetStb));
  pir_row_s rows [4] = '{
    '{8'hFE, 8'h12, 8'hFE, 8'h12, 0},
    '{8'hF0, 8'h07, 8'hF0, 8'h00, 0},
    '{8'h20, 8'h5A, 8'hF1, 8'h00, 1},
    '{8'hB7, 8'hA5, 8'h20, 8'h00, 1}};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // strobes are single cycles, so count them as they pass
  always @(posedge ref_clk) begin
    if (pageWrStb === 1'b1) begin
      stbCnt++;
      lastA = pageWrAddr;
      lastD = pageWrData;
    end
    if (softResetStb === 1'b1) rstCnt++;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // strap is only taken while reset is held
  task automatic do_reset(input logic [1:0] s);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    addrStrap <= s;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  // 3 ns offset keeps scl edges apart from ref_clk edges
  task automatic hdr(input logic [7:0] r);
    #3 c_u.start();
    c_u.byte_io({devA, 1'b0}, 1'b1, rb, ack);
    chk1(ack, 1'b0);
    c_u.byte_io(r, 1'b1, rb, ack);
    chk1(ack, 1'b0);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d, input int n);
    hdr(r);
    for (int i = 0; i < n; i++) begin
      c_u.byte_io(d + 8'(i), 1'b1, rb, ack);
      chk1(ack, 1'b0);
    end
    c_u.stop();
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] v);
    hdr(r);
    c_u.start();
    c_u.byte_io({devA, 1'b1}, 1'b1, rb, ack);
    chk1(ack, 1'b0);
    c_u.byte_io(8'hFF, 1'b1, v, ack);
    c_u.stop();
    repeat (8) @(posedge ref_clk);
  endtask
  // event sources pulse for one ref_clk cycle
  task automatic pulse(input logic [1:0] os, input logic [2:0] pd);
    @(posedge ref_clk);
    openEvent <= os[0];
    shortEvent <= os[1];
    patternDone <= pd;
    @(posedge ref_clk);
    openEvent <= 1'b0;
    shortEvent <= 1'b0;
    patternDone <= 3'b000;
    repeat (4) @(posedge ref_clk);
  endtask
  // hang guard, well above the expected run of about 230 us
  initial begin
    #1000000;
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    addrStrap = 2'h0;
    openEvent = 1'b0;
    shortEvent = 1'b0;
    patternDone = 3'b000;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      chk8(pageSel, 8'h00);
      chk1(irqOutN, 1'b1);
      devA = {3'b101, NIB[(s + 1) % 4]};
      #3 c_u.start();
      c_u.byte_io({devA, 1'b0}, 1'b1, rb, ack);
      chk1(ack, 1'b1);
      c_u.stop();
      devA = {3'b101, NIB[s]};
      rd(8'hFE, val);
      chk8(val, 8'h00);
    end
    foreach (rows[k]) begin
      n0 = stbCnt;
      wr(rows[k].r, rows[k].d, 1);
      chk8(8'(stbCnt - n0), 8'(rows[k].stb));
      if (rows[k].stb != 0) chk8(lastD, rows[k].d);
      if (rows[k].stb != 0) chk8(lastA, rows[k].r);
      rd(rows[k].rr, val);
      chk8(val, rows[k].exp);
    end
    wr(8'hFD, 8'h01, 1);
    chk8(pageSel, 8'h00);
    for (int p = 1; p < 5; p++) begin
      wr(8'hFE, 8'hC5, 1);
      wr(8'hFD, 8'(p % 4), 1);
      chk8(pageSel, 8'(p % 4));
    end
    wr(8'hFE, 8'hC5, 1);
    wr(8'hFD, 8'h07, 1);
    chk8(pageSel, 8'h00);
    wr(8'hFD, 8'h02, 1);
    chk8(pageSel, 8'h02);
    rd(8'hFE, val);
    chk8(val, 8'h00);
    wr(8'hFD, 8'h01, 1);
    chk8(pageSel, 8'h02);
    // a read the controller acks runs on; the pointer stays on the register
    wr(8'hFE, 8'h3C, 1);
    hdr(8'hFE);
    c_u.start();
    c_u.byte_io({devA, 1'b1}, 1'b1, rb, ack);
    chk1(ack, 1'b0);
    c_u.byte_io(8'hFF, 1'b0, val, ack);
    chk8(val, 8'h3C);
    c_u.byte_io(8'hFF, 1'b1, val, ack);
    chk8(val, 8'h3C);
    c_u.stop();
    repeat (8) @(posedge ref_clk);
    n0 = stbCnt;
    wr(8'h30, 8'hA1, 3);
    chk8(8'(stbCnt - n0), 8'h03);
    chk8(lastA, 8'h32);
    chk8(lastD, 8'hA3);
    // masked short, enabled open, no auto clear; then breathing, then auto clear on short
    wr(8'hF0, 8'h01, 1);
    pulse(2'b10, 3'b000);
    chk1(irqOutN, 1'b1);
    pulse(2'b01, 3'b000);
    chk1(irqOutN, 1'b0);
    repeat (100) @(posedge ref_clk);
    chk1(irqOutN, 1'b0);
    rd(8'hF1, val);
    chk8(val, 8'h03);
    chk1(irqOutN, 1'b1);
    wr(8'hF0, 8'h04, 1);
    pulse(2'b00, 3'b111);
    chk1(irqOutN, 1'b0);
    rd(8'hF1, val);
    chk8(val, 8'h1C);
    wr(8'hF0, 8'h0A, 1);
    pulse(2'b10, 3'b000);
    chk1(irqOutN, 1'b0);
    repeat (60) @(posedge ref_clk);
    chk1(irqOutN, 1'b1);
    rd(8'hF1, val);
    chk8(val, 8'h00);
    // register 11h only resets from the function page
    n0 = rstCnt;
    rd(8'h11, val);
    chk8(8'(rstCnt - n0), 8'h00);
    wr(8'hFE, 8'hC5, 1);
    wr(8'hFD, 8'h03, 1);
    wr(8'hF0, 8'h01, 1);
    pulse(2'b01, 3'b000);
    rd(8'h11, val);
    chk8(8'(rstCnt - n0), 8'h01);
    chk8(pageSel, 8'h00);
    chk1(irqOutN, 1'b1);
    wr(8'hFD, 8'h01, 1);
    chk8(pageSel, 8'h00);
    final_report();
  end
endmodule // paged_i2c_register_port_bench
`default_nettype wire
